// ===== dpo_octet_handler.sv
`timescale 1ns/1ps
module dpo_octet_handler (
    input  wire logic                           sys_clk,
    input  wire logic                           rst,
    input  wire logic [dpo_pkg::ADDR_W-1:0]     slave_addr,
    input  wire logic                           maintenance_mode2,
    input  wire dpo_pkg::dpo_octet_s [1:0]      octet_in,
    input  wire logic [1:0]                     deselect,
    input  wire logic [1:0]                     in_select_state,
    input  wire logic [1:0]                     reserved,
    input  wire logic [1:0]                     drivers_quiet_state,
    input  wire logic [1:0]                     req_seq_end,
    input  wire logic [1:0]                     read_status_ctl,
    input  wire dpo_pkg::dpo_status_s [1:0]     status_in,
    output dpo_pkg::dpo_reply_s [1:0]           reply_out,
    output logic [1:0]                          sel_accept,
    output logic [1:0]                          sel_refuse,
    output logic [1:0]                          selected,
    output logic                                alleg_valid,
    output logic                                alleg_port,
    output logic [1:0]                          hold_active,
    output logic [1:0]                          drivers_released,
    output logic [1:0]                          logical_reset,
    output logic [1:0]                          physical_reset,
    output logic [1:0]                          terminate,
    output logic                                slave_reset
);
    import dpo_pkg::*;

    logic [1:0] addr_hit;
    logic [1:0] is_rst;
    logic [1:0] is_sel;
    logic [1:0] is_req_ts;
    logic [1:0] is_req_int;
    logic [1:0] rst_rel;
    logic [1:0] rst_full;
    logic [1:0] lrst;
    logic [1:0] prst;
    logic [1:0] own_hold;
    logic [1:0] own_prio;
    logic [1:0] other_busy;
    logic [1:0] other_idle;
    logic [1:0] win;
    logic [1:0] take;
    logic [1:0] prio_win;
    logic       full_rst;

    logic [1:0] sel_reg;
    logic [1:0] sel_next;
    logic [1:0] hold_reg;
    logic [1:0] hold_next;
    logic [1:0] both_reg;
    logic [1:0] both_next;
    logic [1:0] prio_seen_reg;
    logic [1:0] prio_seen_next;
    logic [1:0] rel_reg;
    logic [1:0] term_next;
    logic       av_reg;
    logic       av_next;
    logic       ap_reg;
    logic       ap_next;

    dpo_reply_s [1:0] reply_reg;
    dpo_reply_s [1:0] reply_next;
    logic [1:0]       acc_reg;
    logic [1:0]       ref_reg;
    logic [1:0]       lrst_reg;
    logic [1:0]       prst_reg;
    logic [1:0]       term_reg;
    logic             srst_reg;

    for (genvar g = 0; g < NPORT; g++) begin : g_dec
        localparam int O = 1 - g;

        assign addr_hit[g]   = octet_in[g].data[ADDR_HI:ADDR_LO] == slave_addr;
        assign is_rst[g]     = octet_in[g].valid && octet_in[g].kind == DPO_OCT_RESET
                               && octet_in[g].data[BIT_ID] && addr_hit[g];
        assign is_sel[g]     = octet_in[g].valid && octet_in[g].kind == DPO_OCT_SELECT
                               && !octet_in[g].data[BIT_ID]
                               && octet_in[g].data[3:2] == SEL_PAD && addr_hit[g];
        assign is_req_ts[g]  = octet_in[g].valid && octet_in[g].kind == DPO_OCT_REQUEST
                               && octet_in[g].data[BIT_ID]
                               && octet_in[g].data[3:0] == REQ_TS_LOW && addr_hit[g];
        assign is_req_int[g] = octet_in[g].valid && octet_in[g].kind == DPO_OCT_REQUEST
                               && octet_in[g].data[BIT_ID]
                               && octet_in[g].data[3:0] == REQ_INT_LOW && addr_hit[g];

        // Each reset type acts independently of the others
        assign rst_rel[g]  = is_rst[g] && octet_in[g].data[RST_RELEASE];
        assign rst_full[g] = is_rst[g] && octet_in[g].data[RST_SLAVE];
        assign lrst[g]     = is_rst[g] && octet_in[g].data[RST_LOGIC];
        assign prst[g]     = is_rst[g] && octet_in[g].data[RST_PHYS];

        assign own_hold[g] = octet_in[g].data[SEL_HOLD];
        assign own_prio[g] = octet_in[g].data[SEL_PRIO];

        // Other port is protected only while selected, reserved or holding
        assign other_busy[g] = av_reg && (ap_reg != 1'(g));
        assign other_idle[g] = !sel_reg[O] && !reserved[O] && !hold_reg[O];
        assign win[g] = !other_busy[g] || other_idle[g]
                        || (own_hold[g] && own_prio[g] && !both_reg[O])
                        || (!own_hold[g] && own_prio[g] && !hold_reg[O]);

        // Same-cycle selections on both ports: port 1 is always refused
        if (g == 0) begin : g_first
            assign take[g] = is_sel[g] && win[g];
        end else begin : g_second
            assign take[g] = is_sel[g] && win[g] && !is_sel[0];
        end
        assign prio_win[g] = take[g] && own_prio[g];

        always_comb begin
            reply_next[g].valid = is_req_ts[g] || is_req_int[g];
            if (is_req_ts[g]) begin
                // Fixed values reflect command/response transfers
                reply_next[g].data = {1'b0, maintenance_mode2, TS_FIXED};
            end else if (is_req_int[g]) begin
                reply_next[g].data = {1'b0,
                                      status_in[g].busy || other_busy[g],
                                      status_in[g].ready,
                                      hold_reg[O],
                                      prio_seen_reg[g],
                                      status_in[g].cls};
            end else begin
                reply_next[g].data = REPLY_RST;
            end
        end

        // Only this port's master can end its own release
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                rel_reg[g] <= 1'b0;
            end else if (is_rst[g]) begin
                rel_reg[g] <= rst_rel[g];
            end
        end
    end

    assign full_rst = |rst_full;

    always_comb begin
        sel_next  = sel_reg;
        hold_next = hold_reg;
        both_next = both_reg;
        av_next   = av_reg;
        ap_next   = ap_reg;
        term_next = PORT_RST;
        for (int p = 0; p < NPORT; p++) begin
            if (deselect[p]) begin
                sel_next[p] = 1'b0;
                if (av_reg && ap_reg == 1'(p) && !hold_reg[p] && !reserved[p]) begin
                    av_next = 1'b0;
                end
            end
            if (lrst[p]) begin
                sel_next[p]  = 1'b0;
                hold_next[p] = 1'b0;
                both_next[p] = 1'b0;
                if (av_reg && ap_reg == 1'(p)) begin
                    av_next = 1'b0;
                end
            end
        end
        for (int p = 0; p < NPORT; p++) begin
            if (take[p]) begin
                sel_next[p]  = 1'b1;
                hold_next[p] = own_hold[p];
                both_next[p] = own_hold[p] && own_prio[p];
                av_next      = 1'b1;
                ap_next      = 1'(p);
                // Losing port gives up its selection and any hold
                sel_next[1-p]  = 1'b0;
                hold_next[1-p] = 1'b0;
                both_next[1-p] = 1'b0;
                term_next[1-p] = own_prio[p] && sel_reg[1-p] && !in_select_state[1-p];
            end
        end
        for (int p = 0; p < NPORT; p++) begin
            // A new priority select beats a same-cycle clear
            prio_seen_next[p] = (prio_seen_reg[p] && !req_seq_end[p] && !read_status_ctl[p])
                                || prio_win[1-p];
        end
        if (full_rst) begin
            sel_next       = PORT_RST;
            hold_next      = PORT_RST;
            both_next      = PORT_RST;
            prio_seen_next = PORT_RST;
            term_next      = PORT_RST;
            av_next        = 1'b0;
            ap_next        = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sel_reg       <= PORT_RST;
            hold_reg      <= PORT_RST;
            both_reg      <= PORT_RST;
            prio_seen_reg <= PORT_RST;
            av_reg        <= 1'b0;
            ap_reg        <= 1'b0;
        end else begin
            sel_reg       <= sel_next;
            hold_reg      <= hold_next;
            both_reg      <= both_next;
            prio_seen_reg <= prio_seen_next;
            av_reg        <= av_next;
            ap_reg        <= ap_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reply_reg <= '0;
            acc_reg   <= PORT_RST;
            ref_reg   <= PORT_RST;
            lrst_reg  <= PORT_RST;
            prst_reg  <= PORT_RST;
            term_reg  <= PORT_RST;
            srst_reg  <= 1'b0;
        end else begin
            reply_reg <= reply_next;
            acc_reg   <= take;
            ref_reg   <= is_sel & ~take;
            lrst_reg  <= lrst;
            prst_reg  <= prst;
            term_reg  <= term_next;
            srst_reg  <= full_rst;
        end
    end

    assign reply_out        = reply_reg;
    assign sel_accept       = acc_reg;
    assign sel_refuse       = ref_reg;
    assign selected         = sel_reg;
    assign alleg_valid      = av_reg;
    assign alleg_port       = ap_reg;
    assign hold_active      = hold_reg;
    assign drivers_released = rel_reg | drivers_quiet_state;
    assign logical_reset    = lrst_reg;
    assign physical_reset   = prst_reg;
    assign terminate        = term_reg;
    assign slave_reset      = srst_reg;

    slave_reset_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        rst_full[0] |=> slave_reset && !alleg_valid && selected == 2'h0 && hold_active == 2'h0)
        else $error("slave reset did not clear state");

    release_set_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        rst_rel[0] |=> drivers_released[0][*3] or (drivers_released[0] && is_rst[0])
        or (drivers_released[0] ##1 is_rst[0]))
        else $error("drivers not released");

    release_keep_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        rel_reg[1] && !is_rst[1] |=> rel_reg[1])
        else $error("release ended without own reset");

    logical_rst_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        lrst[1] |=> logical_reset[1] && !selected[1] && !hold_active[1])
        else $error("logical reset not applied");

    physical_rst_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        prst[1] |=> physical_reset[1] ##1 !physical_reset[1] || $past(prst[1]))
        else $error("physical reset pulse wrong");

    one_alleg_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        !(selected[0] && selected[1]) && (selected == 2'h0 || (alleg_valid && selected[alleg_port])))
        else $error("allegiance to two ports");

    hold_keep_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        hold_active[0] && alleg_valid && !alleg_port && is_sel == 2'h0 && is_rst == 2'h0
        |=> alleg_valid && !alleg_port && hold_active[0])
        else $error("hold allegiance lost");

    both_steal_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        is_sel[1] && own_hold[1] && own_prio[1] && !both_reg[0] && !is_sel[0] && !full_rst
        |=> sel_accept[1] && alleg_port && !hold_active[0])
        else $error("hold and select did not win");

    prio_refused_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        is_sel[1] && !own_hold[1] && own_prio[1] && hold_reg[0] && other_busy[1]
        |=> sel_refuse[1] && !sel_accept[1])
        else $error("select overrode a hold");

    terminate_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        prio_win[1] && sel_reg[0] && !in_select_state[0] && !full_rst |=> terminate[0])
        else $error("other selection not terminated");

    settings_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        is_req_ts[0] |=> reply_out[0].valid && reply_out[0].data[7:6] == {1'b0, $past(maintenance_mode2)}
        && reply_out[0].data[5:0] == TS_FIXED)
        else $error("transfer settings reply wrong");

    int_bits_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        is_req_int[1] |=> reply_out[1].valid && reply_out[1].data[4] == $past(hold_reg[0])
        && reply_out[1].data[3] == $past(prio_seen_reg[1]))
        else $error("slave interrupts reply wrong");

    prio_seen_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        prio_win[0] && !full_rst |=> prio_seen_reg[1])
        else $error("priority select flag not set");

    addr_skip_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        octet_in[0].valid && !addr_hit[0] |=> !reply_out[0].valid && !sel_accept[0] && !sel_refuse[0])
        else $error("acted on foreign address");

endmodule : dpo_octet_handler

// ===== dpo_pkg.sv
package dpo_pkg;

    localparam int NPORT  = 2;
    localparam int ADDR_W = 3;

    // Common octet fields
    localparam int BIT_ID  = 7;
    localparam int ADDR_HI = 6;
    localparam int ADDR_LO = 4;

    // Selective reset octet
    localparam int RST_RELEASE = 3;
    localparam int RST_SLAVE   = 2;
    localparam int RST_LOGIC   = 1;
    localparam int RST_PHYS    = 0;

    // Selection octet
    localparam int       SEL_HOLD = 1;
    localparam int       SEL_PRIO = 0;
    localparam logic [1:0] SEL_PAD = 2'h0;

    // Request octets, low nibble
    localparam logic [3:0] REQ_TS_LOW  = 4'h0;
    localparam logic [3:0] REQ_INT_LOW = 4'h8;

    // Transfer settings: double octet, interlocked, no streaming
    localparam logic [5:0] TS_FIXED = 6'h26;

    // Reset values
    localparam logic [1:0] PORT_RST  = 2'h0;
    localparam logic [7:0] REPLY_RST = 8'h00;

    typedef enum logic [1:0] {
        DPO_OCT_RESET   = 2'b00,
        DPO_OCT_SELECT  = 2'b01,
        DPO_OCT_REQUEST = 2'b10,
        DPO_OCT_OTHER   = 2'b11
    } dpo_kind_e;

    typedef struct packed {
        logic      valid;
        dpo_kind_e kind;
        logic [7:0] data;
    } dpo_octet_s;

    typedef struct packed {
        logic       busy;
        logic       ready;
        logic [2:0] cls;
    } dpo_status_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } dpo_reply_s;

endpackage : dpo_pkg

// ===== dpo_master_pair.sv
`timescale 1ns/1ps
module dpo_master_pair (
    input  wire logic                  sys_clk,
    output dpo_pkg::dpo_octet_s [1:0]  octet_in,
    output logic [1:0]                 deselect,
    output logic [1:0]                 in_select_state,
    output logic [1:0]                 reserved,
    output logic [1:0]                 req_seq_end,
    output logic [1:0]                 read_status_ctl
);
    import dpo_pkg::*;

    initial begin
        octet_in        = '0;
        deselect        = 2'h0;
        in_select_state = 2'h0;
        reserved        = 2'h0;
        req_seq_end     = 2'h0;
        read_status_ctl = 2'h0;
    end

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick

    function automatic dpo_octet_s sel_oct(input logic [2:0] a, input logic [1:0] hs);
        return '{1'b1, DPO_OCT_SELECT, {1'b0, a, SEL_PAD, hs}};
    endfunction : sel_oct

    function automatic dpo_octet_s rst_oct(input logic [2:0] a, input logic [3:0] code);
        return '{1'b1, DPO_OCT_RESET, {1'b1, a, code}};
    endfunction : rst_oct

    function automatic dpo_octet_s req_oct(input logic [2:0] a, input logic intr);
        return '{1'b1, DPO_OCT_REQUEST, {1'b1, a, intr ? REQ_INT_LOW : REQ_TS_LOW}};
    endfunction : req_oct

    // Idle lines show the inverse so a stale octet is never mistaken for a fresh one
    task automatic send(input dpo_octet_s a, input dpo_octet_s b);
        tick;
        octet_in[0] = a;
        octet_in[1] = b;
        tick;
        octet_in[0] = '{1'b0, a.kind, ~a.data};
        octet_in[1] = '{1'b0, b.kind, ~b.data};
    endtask : send

    task automatic pulse(input logic [1:0] dsel, input logic [1:0] rqe);
        tick;
        deselect    = dsel;
        req_seq_end = rqe;
        tick;
        deselect    = 2'h0;
        req_seq_end = 2'h0;
    endtask : pulse

    task automatic ctl_pulse(input logic [1:0] rsc);
        tick;
        read_status_ctl = rsc;
        tick;
        read_status_ctl = 2'h0;
    endtask : ctl_pulse

    // Levels move only just after an edge, like the octets
    task automatic levels(input logic [1:0] ss, input logic [1:0] rs);
        tick;
        in_select_state = ss;
        reserved        = rs;
    endtask : levels
endmodule : dpo_master_pair

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import dpo_pkg::*;
    logic              sys_clk, rst, maintenance_mode2, alleg_valid, alleg_port, slave_reset;
    logic [2:0]        slave_addr, own, nz;
    logic [1:0]        deselect, in_select_state, reserved, drivers_quiet_state, req_seq_end, read_status_ctl;
    logic [1:0]        sel_accept, sel_refuse, selected, hold_active, drivers_released;
    logic [1:0]        logical_reset, physical_reset, terminate;
    dpo_octet_s [1:0]  octet_in;
    dpo_status_s [1:0] status_in;
    dpo_reply_s [1:0]  reply_out;
    dpo_octet_s        nil;
    logic [10:0]       expq[$];
    logic [31:0]       seed, r;
    int                error_cnt, checks, cyc;

    dpo_octet_handler uut (.sys_clk, .rst, .slave_addr, .maintenance_mode2, .octet_in, .deselect,
        .in_select_state, .reserved, .drivers_quiet_state, .req_seq_end, .read_status_ctl,
        .status_in, .reply_out, .sel_accept, .sel_refuse, .selected, .alleg_valid, .alleg_port,
        .hold_active, .drivers_released, .logical_reset, .physical_reset, .terminate, .slave_reset);
    dpo_master_pair master (.sys_clk, .octet_in, .deselect, .in_select_state, .reserved,
        .req_seq_end, .read_status_ctl);

    always #10 sys_clk = ~sys_clk;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic fail(input string what, input logic [10:0] got, input logic [10:0] exp);
        error_cnt++;
        $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    endtask : fail

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) fail(what, {3'h0, got}, {3'h0, exp});
    endtask : chk

    // Kind 0 reply, 1 accept, 2 refuse
    task automatic note(input logic [1:0] k, input logic p, input logic [7:0] d);
        expq.push_back({k, p, d});
    endtask : note

    task automatic take(input logic [10:0] got);
        logic [10:0] e;
        checks++;
        if (expq.size() == 0) begin
            fail("unexpected answer", got, 11'h000);
        end else begin
            e = expq.pop_front();
            if (got !== e) fail("answer mismatch", got, e);
        end
    endtask : take

    always @(posedge sys_clk) begin
        #1;
        for (int p = 0; p < 2; p++) begin
            if (reply_out[p].valid === 1'b1) take({2'd0, p[0], reply_out[p].data});
            if (sel_accept[p] === 1'b1) take({2'd1, p[0], 8'h00});
            if (sel_refuse[p] === 1'b1) take({2'd2, p[0], 8'h00});
        end
    end

    task automatic end_of_test;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    // Whole sequence is well under a thousand cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            end_of_test();
        end
    end

    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        seed = 32'h0000_4722;
        r = xs();
        own = r[2:0];
        slave_addr = own;
        maintenance_mode2 = 1'b0;
        drivers_quiet_state = 2'h0;
        status_in = '0;
        nil = '0;
        repeat (6) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        note(2'd1, 1'b0, 8'h00);
        note(2'd2, 1'b1, 8'h00);
        master.send(master.sel_oct(own, 2'b00), master.sel_oct(own, 2'b00));
        chk({alleg_valid, alleg_port}, 8'h02, "alleg after tie");
        chk({6'h0, selected}, 8'h01, "selected after tie");
        note(2'd1, 1'b1, 8'h00);
        master.send(nil, master.sel_oct(own, 2'b01));
        chk({6'h0, terminate}, 8'h01, "terminate");
        chk({alleg_valid, alleg_port}, 8'h03, "alleg after select");
        status_in[0] = '{1'b0, 1'b1, 3'h5};
        note(2'd0, 1'b0, 8'h6D);
        master.send(master.req_oct(own, 1'b1), nil);
        master.pulse(2'b00, 2'b01);
        note(2'd0, 1'b0, 8'h65);
        master.send(master.req_oct(own, 1'b1), nil);
        master.pulse(2'b10, 2'b00);
        note(2'd1, 1'b0, 8'h00);
        master.send(master.sel_oct(own, 2'b10), nil);
        chk({6'h0, hold_active}, 8'h01, "hold set");
        master.pulse(2'b01, 2'b00);
        chk({alleg_valid, alleg_port}, 8'h02, "hold past deselect");
        note(2'd2, 1'b1, 8'h00);
        master.send(nil, master.sel_oct(own, 2'b01));
        status_in[1] = '{1'b0, 1'b1, 3'h2};
        note(2'd0, 1'b1, 8'h72);
        master.send(nil, master.req_oct(own, 1'b1));
        note(2'd1, 1'b1, 8'h00);
        master.send(nil, master.sel_oct(own, 2'b11));
        chk({6'h0, hold_active}, 8'h02, "hold moved");
        note(2'd2, 1'b0, 8'h00);
        master.send(master.sel_oct(own, 2'b11), nil);
        master.pulse(2'b10, 2'b00);
        chk({alleg_valid, alleg_port}, 8'h03, "both past deselect");
        note(2'd1, 1'b1, 8'h00);
        master.send(nil, master.sel_oct(own, 2'b00));
        chk({6'h0, hold_active}, 8'h00, "hold ended");
        note(2'd0, 1'b0, 8'h6D);
        master.send(master.req_oct(own, 1'b1), nil);
        master.ctl_pulse(2'b01);
        note(2'd0, 1'b0, 8'h65);
        master.send(master.req_oct(own, 1'b1), nil);
        master.levels(2'b10, 2'b00);
        note(2'd1, 1'b0, 8'h00);
        master.send(master.sel_oct(own, 2'b01), nil);
        chk({6'h0, terminate}, 8'h00, "no terminate in select");
        master.levels(2'b00, 2'b01);
        master.pulse(2'b01, 2'b00);
        note(2'd2, 1'b1, 8'h00);
        master.send(nil, master.sel_oct(own, 2'b00));
        chk({alleg_valid, alleg_port}, 8'h02, "reserved keeps");
        master.levels(2'b00, 2'b00);
        for (int m = 0; m < 2; m++) begin
            maintenance_mode2 = m[0];
            note(2'd0, m[0], {1'b0, m[0], TS_FIXED});
            master.send(m == 0 ? master.req_oct(own, 1'b0) : nil, m == 1 ? master.req_oct(own, 1'b0) : nil);
        end
        for (int i = 0; i < 4; i++) begin
            r = xs();
            nz = (r[2:0] == 3'h0) ? 3'h1 : r[2:0];
            master.send(master.req_oct(own ^ nz, 1'b1), master.sel_oct(own ^ nz, r[4:3]));
        end
        master.send('{1'b1, DPO_OCT_REQUEST, {1'b1, own, 4'h4}}, nil);
        master.pulse(2'b10, 2'b00);
        note(2'd1, 1'b0, 8'h00);
        master.send(master.sel_oct(own, 2'b10), nil);
        master.send(nil, master.rst_oct(own, 4'h4));
        chk({5'h0, slave_reset, hold_active}, 8'h04, "slave reset");
        chk({7'h0, alleg_valid}, 8'h00, "alleg after slave reset");
        for (int c = 0; c < 16; c++) begin
            master.send(c[0] ? nil : master.rst_oct(own, c[3:0]), c[0] ? master.rst_oct(own, c[3:0]) : nil);
            chk({6'h0, logical_reset}, c[1] ? (8'h01 << c[0]) : 8'h00, "logical");
            chk({6'h0, physical_reset}, c[0] ? 8'h02 : 8'h00, "physical");
            chk({7'h0, slave_reset}, {7'h0, c[2]}, "full");
            chk({7'h0, drivers_released[c[0]]}, {7'h0, c[3]}, "release");
        end
        master.send(nil, master.rst_oct(own, 4'h0));
        chk({6'h0, drivers_released}, 8'h01, "release kept");
        drivers_quiet_state = 2'b10;
        #1;
        chk({6'h0, drivers_released}, 8'h03, "quiet state");
        master.send(master.rst_oct(own, 4'h0), nil);
        chk({6'h0, drivers_released}, 8'h02, "release ended");
        master.tick;
        chk(expq.size(), 8'h00, "answers outstanding");
        end_of_test();
    end
endmodule : tb_top
